// ---- rtl/lic_pkg.sv ----
// Package for the inhibit control block: widths, address, timing, carriers.
// Assumes a single system clock domain plus a serial link clock domain.
package lic_pkg;
  // Pin group widths
  localparam int SEG_W = 60;
  localparam int COM_W = 10;
  localparam int PORT_W = 4;
  localparam int SCAN_W = 6;
  localparam int KEY_W = 30;
  // Address is two nibbles sent low nibble first (arbitrary value)
  localparam logic [7:0] DEV_ADDR = 8'h42;
  localparam int ADDR_W = 8;
  localparam int NIB_W = 4;
  // Payload layout: port state bits in the low four bits, direction in two bits
  localparam int PAYLOAD_W = 8;
  localparam int PORT_LSB = 0;
  localparam logic [1:0] DIR_CTRL = 2'h1;
  localparam logic [1:0] DIR_W = 2'h0;
  localparam logic [PORT_W-1:0] PORT_RST = 4'h0;
  localparam logic [PAYLOAD_W-1:0] PAYLOAD_RST = 8'h00;
  // Key scan step time in ns and cycles at 40 MHz
  localparam int CLK_NS = 25;
  localparam int SCAN_STEP_NS = 1000;
  localparam int SCAN_STEP_CYC = (SCAN_STEP_NS + CLK_NS - 1) / CLK_NS;
  // Direction plus payload carried across domains
  typedef struct packed {
    logic [1:0] dir;
    logic [PAYLOAD_W-1:0] data;
  } lic_word_t;
endpackage : lic_pkg

// ---- rtl/lic_inhibit_ctrl.sv ----
// Inhibit control of a segment LCD driver with key scan and output ports.
// Assumes the link clock idles low outside frames and the enable frames a transfer.
// Overview of operation
// - Inhibit low: segments and commons at lowest bias
// - Inhibit low: four port outputs forced low
// - Inhibit low: scanning stops, scan drives low
// - Inhibit low clears all stored key data
// - Inhibit high: display, scanning, ports normal
// - Serial reception continues while inhibited
// - Transfer carries two address nibbles, direction
// - Duty formats differ; clock idles low
// - Serial data output is open-drain pull-low
module lic_inhibit_ctrl #(
  parameter int SCAN_STEP = lic_pkg::SCAN_STEP_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic INHIBIT_N_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic SERIAL_ENABLE_IN,
  input wire logic SERIAL_IN_IN,
  input wire logic [lic_pkg::KEY_W/lic_pkg::SCAN_W-1:0] KEY_IN,
  input wire logic [lic_pkg::SEG_W-1:0] SEG_DATA_IN,
  output logic [lic_pkg::SEG_W-1:0] SEGMENT_OUTPUTS_OUT,
  output logic [lic_pkg::COM_W-1:0] COMMON_OUTPUTS_OUT,
  output logic [lic_pkg::PORT_W-1:0] PORT_OUTPUTS_OUT,
  output logic [lic_pkg::SCAN_W-1:0] SCAN_DRIVE_OUTPUTS_OUT,
  output logic [lic_pkg::KEY_W-1:0] KEY_DATA_OUT,
  output logic SERIAL_OUT_OUT,
  output logic SERIAL_OUT_OE_OUT
);
  localparam int RET_W = lic_pkg::KEY_W / lic_pkg::SCAN_W; // Key return lines per step
  localparam int FRAME_W = lic_pkg::ADDR_W + lic_pkg::PAYLOAD_W + 2;

  // Elaboration check on the scan step; the step counter is 16 bits wide
  if (SCAN_STEP < 1 || SCAN_STEP > 2 ** 16)
  begin : g_bad_step
    $error("SCAN_STEP must fit the 16-bit step counter and be at least one");
  end

  // ---------------- Link domain ----------------
  logic [FRAME_W-1:0] shift;         // Incoming bits, first bit ends up high
  logic [FRAME_W-1:0] next_shift;
  logic [5:0] bit_cnt;               // Bits seen in this frame
  logic [5:0] next_bit_cnt;
  lic_pkg::lic_word_t link_word;     // Last accepted word, held stable
  lic_pkg::lic_word_t next_link_word;
  logic link_tog;                    // Toggles per accepted word
  logic next_link_tog;
  logic frame_ok;

  // Address check on the completed frame; low nibble arrives first
  always_comb
  begin
    frame_ok = (bit_cnt == 6'(FRAME_W)) &&
      ({shift[FRAME_W-lic_pkg::NIB_W-1 -: lic_pkg::NIB_W],
        shift[FRAME_W-1 -: lic_pkg::NIB_W]} == lic_pkg::DEV_ADDR);
  end

  // Shift next values; the frame is taken on the first rising clock edge seen with enable low
  always_comb
  begin
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_link_word = link_word;
    next_link_tog = link_tog;
    if (SERIAL_ENABLE_IN)
    begin
      next_shift = {shift[FRAME_W-2:0], SERIAL_IN_IN};
      if (bit_cnt != 6'(FRAME_W))
      begin
        next_bit_cnt = bit_cnt + 6'h01;
      end
    end
    else
    begin
      next_bit_cnt = 6'h00;
    end
    if (frame_ok && !SERIAL_ENABLE_IN)
    begin
      next_link_word = shift[lic_pkg::PAYLOAD_W+1:0];
      next_link_tog = ~link_tog;
    end
  end

  // Link registers; the last edge is the one that closes the frame
  always_ff @(posedge SERIAL_CLOCK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      shift <= '0;
      bit_cnt <= 6'h00;
      link_word <= '0;
      link_tog <= 1'b0;
    end
    else
    begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      link_word <= next_link_word;
      link_tog <= next_link_tog;
    end
  end

  // ---------------- System domain ----------------
  logic [2:0] tog_sync;              // Toggle synchroniser plus edge stage
  logic [2:0] next_tog_sync;
  logic [1:0] inhibit_sync;          // Inhibit pin synchroniser
  logic [1:0] next_inhibit_sync;
  logic [1:0] enable_sync;           // Frame enable seen from the system side
  logic [1:0] next_enable_sync;
  logic [2*RET_W-1:0] key_sync;      // Key return synchroniser
  logic [2*RET_W-1:0] next_key_sync;
  logic [lic_pkg::PORT_W-1:0] port_q; // Registered port pins
  logic [lic_pkg::PORT_W-1:0] next_port_q;
  logic oe_q;                        // Registered pull-low enable
  logic next_oe_q;
  logic [lic_pkg::PORT_W-1:0] port_state;
  logic [lic_pkg::PORT_W-1:0] next_port_state;
  logic [lic_pkg::KEY_W-1:0] key_data;
  logic [lic_pkg::KEY_W-1:0] next_key_data;
  logic [lic_pkg::SCAN_W-1:0] scan_ring;  // One-hot scan drive
  logic [lic_pkg::SCAN_W-1:0] next_scan_ring;
  logic [15:0] step_cnt;
  logic [15:0] next_step_cnt;
  logic [2:0] scan_idx;
  logic [2:0] next_scan_idx;
  logic [lic_pkg::SEG_W-1:0] seg_q;
  logic [lic_pkg::SEG_W-1:0] next_seg_q;
  logic [lic_pkg::COM_W-1:0] com_q;
  logic [lic_pkg::COM_W-1:0] next_com_q;
  logic [lic_pkg::COM_W-1:0] com_ring;
  logic [lic_pkg::COM_W-1:0] next_com_ring;
  logic inhibited;
  logic word_evt;
  lic_pkg::lic_word_t rx_word;

  assign inhibited = ~inhibit_sync[1];
  assign word_evt = tog_sync[2] ^ tog_sync[1];
  // Word is stable for many link cycles after the toggle, safe to sample
  assign rx_word = link_word;

  // System next values
  always_comb
  begin
    next_tog_sync = {tog_sync[1:0], link_tog};
    next_inhibit_sync = {inhibit_sync[0], INHIBIT_N_IN};
    // Enable is a pin of the link side, so it is synchronised before use here
    next_enable_sync = {enable_sync[0], SERIAL_ENABLE_IN};
    next_key_sync = {key_sync[RET_W-1:0], KEY_IN};
    next_port_state = port_state;
    next_key_data = key_data;
    next_scan_ring = scan_ring;
    next_step_cnt = step_cnt;
    next_scan_idx = scan_idx;
    next_com_ring = {com_ring[lic_pkg::COM_W-2:0], com_ring[lic_pkg::COM_W-1]};
    next_seg_q = SEG_DATA_IN;
    next_com_q = com_ring;
    next_port_q = inhibited ? '0 : port_state;
    // Pull low only during a frame with keys
    next_oe_q = enable_sync[1] & (key_data != '0);
    if (word_evt && rx_word.dir == lic_pkg::DIR_CTRL)
    begin
      next_port_state = rx_word.data[lic_pkg::PORT_LSB +: lic_pkg::PORT_W];
    end
    if (inhibited)
    begin
      next_seg_q = '0;
      next_com_q = '0;
      next_scan_ring = '0;
      next_step_cnt = 16'h0000;
      next_scan_idx = 3'h0;
      next_key_data = '0;
    end
    else
    begin
      if (scan_ring == '0)
      begin
        next_scan_ring = {{(lic_pkg::SCAN_W-1){1'b0}}, 1'b1};
      end
      else if (step_cnt == 16'(SCAN_STEP - 1))
      begin
        next_step_cnt = 16'h0000;
        next_key_data[scan_idx*RET_W +: RET_W] = key_sync[2*RET_W-1:RET_W];
        next_scan_ring = {scan_ring[lic_pkg::SCAN_W-2:0], scan_ring[lic_pkg::SCAN_W-1]};
        next_scan_idx = (scan_idx == 3'(lic_pkg::SCAN_W - 1)) ? 3'h0 : scan_idx + 3'h1;
      end
      else
      begin
        next_step_cnt = step_cnt + 16'h0001;
      end
    end
  end

  // System registers
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      tog_sync <= 3'h0;
      inhibit_sync <= 2'h0;
      enable_sync <= 2'h0;
      port_q <= '0;
      oe_q <= 1'b0;
      key_sync <= '0;
      port_state <= lic_pkg::PORT_RST;
      key_data <= '0;
      scan_ring <= '0;
      step_cnt <= 16'h0000;
      scan_idx <= 3'h0;
      seg_q <= '0;
      com_q <= '0;
      com_ring <= {{(lic_pkg::COM_W-1){1'b0}}, 1'b1};
    end
    else
    begin
      tog_sync <= next_tog_sync;
      inhibit_sync <= next_inhibit_sync;
      enable_sync <= next_enable_sync;
      port_q <= next_port_q;
      oe_q <= next_oe_q;
      key_sync <= next_key_sync;
      port_state <= next_port_state;
      key_data <= next_key_data;
      scan_ring <= next_scan_ring;
      step_cnt <= next_step_cnt;
      scan_idx <= next_scan_idx;
      seg_q <= next_seg_q;
      com_q <= next_com_q;
      com_ring <= next_com_ring;
    end
  end

  // Outputs straight from flops, serial data out tied low, so the pins never glitch on a gate
  assign SEGMENT_OUTPUTS_OUT = seg_q;
  assign COMMON_OUTPUTS_OUT = com_q;
  assign PORT_OUTPUTS_OUT = port_q;
  assign SCAN_DRIVE_OUTPUTS_OUT = scan_ring;
  assign KEY_DATA_OUT = key_data;
  assign SERIAL_OUT_OUT = 1'b0;
  assign SERIAL_OUT_OE_OUT = oe_q;

  // ---------------- Assertions ----------------
  a_ports_low: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    inhibited |=> PORT_OUTPUTS_OUT == '0) else $error("ports not low while inhibited");
  a_scan_stop: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    inhibited |=> SCAN_DRIVE_OUTPUTS_OUT == '0) else $error("scan drive active");
  a_key_clear: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    inhibited |=> KEY_DATA_OUT == '0) else $error("key data not cleared");
  a_blank_disp: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    inhibited |=> (SEGMENT_OUTPUTS_OUT == '0 && COMMON_OUTPUTS_OUT == '0))
    else $error("display not blank");
  a_port_normal: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !inhibited |=> PORT_OUTPUTS_OUT == $past(port_state)) else $error("port not from state");
  a_scan_resume: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(inhibit_sync[1]) |=> $onehot(SCAN_DRIVE_OUTPUTS_OUT)) else $error("scan not resumed");
  a_rx_inhibit: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    (word_evt && rx_word.dir == lic_pkg::DIR_CTRL) |=>
    port_state == $past(rx_word.data[lic_pkg::PORT_LSB +: lic_pkg::PORT_W]))
    else $error("word lost");
  a_od_low: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SERIAL_OUT_OE_OUT |-> !SERIAL_OUT_OUT) else $error("open drain drove high");
  c_inhibit: cover property (@(posedge CLK_IN) disable iff (RST_IN) $fell(inhibit_sync[1]));
  c_word_inhibit: cover property (@(posedge CLK_IN) disable iff (RST_IN) word_evt && inhibited);
  c_key: cover property (@(posedge CLK_IN) disable iff (RST_IN) key_data != '0);
endmodule : lic_inhibit_ctrl

// ---- verification/lic_ctrl_model.sv ----
// Controller model: drives frames on the serial link.
// Assumes the block samples data on rising link edges.
module lic_ctrl_model (
  output logic sclk_out,
  output logic sen_out,
  output logic sdat_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sclk_out = 1'b0;
    sen_out = 1'b0;
    sdat_out = 1'b0;
  end
  task automatic send(input logic [17:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      sen_out = 1'b1;
      sdat_out = w[i];
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
    // Closing edge; released data shows no stale bit
    sen_out = 1'b0;
    sdat_out = ~sdat_out;
    #80 sclk_out = 1'b1;
    #80 sclk_out = 1'b0;
  endtask : send
endmodule : lic_ctrl_model

// ---- verification/test_lic_inhibit_ctrl.sv ----
// Bench for the inhibit control block.
// Assumes the controller model on the link and a 40 MHz clock.
module test_lic_inhibit_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 2; // Short scan step keeps the run brief
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic inhibit_n = 1'b1;
  logic [4:0] keys = 5'h00;
  logic [59:0] seg = 60'hA5A5A5A5A5A5A5A;
  logic [59:0] seg_out;
  logic [9:0] com_out;
  logic [3:0] port_out;
  logic [5:0] scan_out;
  logic [29:0] key_out;
  logic so;
  logic so_oe;
  logic sclk;
  logic sen;
  logic sdat;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  // Row: inhibit level, port bits sent, ports expected
  typedef struct packed {logic inhibit; logic [3:0] bits; logic [3:0] exp;} lic_row_t;
  lic_row_t rows [4] = '{'{1'b1, 4'hA, 4'hA}, '{1'b0, 4'h5, 4'h0},
    '{1'b1, 4'hF, 4'hF}, '{1'b1, 4'h0, 4'h0}};
  lic_inhibit_ctrl #(.SCAN_STEP(STEP)) u_lic_inhibit_ctrl (.CLK_IN(clk_in),
    .RST_IN(rst_in), .INHIBIT_N_IN(inhibit_n), .SERIAL_CLOCK_IN(sclk),
    .SERIAL_ENABLE_IN(sen), .SERIAL_IN_IN(sdat), .KEY_IN(keys), .SEG_DATA_IN(seg),
    .SEGMENT_OUTPUTS_OUT(seg_out), .COMMON_OUTPUTS_OUT(com_out),
    .PORT_OUTPUTS_OUT(port_out), .SCAN_DRIVE_OUTPUTS_OUT(scan_out),
    .KEY_DATA_OUT(key_out), .SERIAL_OUT_OUT(so), .SERIAL_OUT_OE_OUT(so_oe));
  lic_ctrl_model u_lic_ctrl_model (.sclk_out(sclk), .sen_out(sen), .sdat_out(sdat));
  // Free-running system clock
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  // Hang guard, far above the expected run length
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("Checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // One frame, then room for the crossing
  task automatic frame(input logic [7:0] a, input logic [1:0] d, input logic [3:0] bits,
    input int n);
    u_lic_ctrl_model.send({a[3:0], a[7:4], d, 4'h0, bits}, n);
    cyc(8);
  endtask : frame
  // Inhibited segment, common, scan and key outputs low
  task automatic blank();
    check("seg", 64'(seg_out), 64'h0);
    check("com", 64'(com_out), 64'h0);
    check("scan", 64'(scan_out), 64'h0);
    check("key", 64'(key_out), 64'h0);
  endtask : blank
  initial
  begin
    cyc(5);
    rst_in = 1'b0;
    cyc(3);
    check("port_rst", 64'(port_out), 64'(lic_pkg::PORT_RST));
    // Table rows: ports follow state bits only when not inhibited
    foreach (rows[i])
    begin
      inhibit_n = rows[i].inhibit;
      frame(lic_pkg::DEV_ADDR, lic_pkg::DIR_CTRL, rows[i].bits, 18);
      check("port", 64'(port_out), 64'(rows[i].exp));
      if (rows[i].inhibit)
      begin
        check("seg_on", 64'(seg_out), 64'(seg));
        check("com_one", 64'($countones(com_out)), 64'h1);
        check("scan_one", 64'($countones(scan_out)), 64'h1);
      end
      else
        blank();
      $display("Row %0d done", i);
    end
    // Word taken while inhibited shows on release
    inhibit_n = 1'b0;
    frame(lic_pkg::DEV_ADDR, lic_pkg::DIR_CTRL, 4'h6, 18);
    check("port_inh", 64'(port_out), 64'h0);
    inhibit_n = 1'b1;
    cyc(5);
    check("port_kept", 64'(port_out), 64'h6);
    $display("Retention done");
    // Bad address, short frame, other direction all ignored
    frame(8'h24, lic_pkg::DIR_CTRL, 4'h9, 18);
    frame(lic_pkg::DEV_ADDR, lic_pkg::DIR_CTRL, 4'h9, 17);
    frame(lic_pkg::DEV_ADDR, 2'h3, 4'h9, 18);
    check("port_ign", 64'(port_out), 64'h6);
    $display("Refusals done");
    // Mid-run reset drops the held port state
    rst_in = 1'b1;
    cyc(2);
    check("port_in_rst", 64'(port_out), 64'h0);
    check("scan_in_rst", 64'(scan_out), 64'h0);
    rst_in = 1'b0;
    cyc(4);
    check("port_after_rst", 64'(port_out), 64'(lic_pkg::PORT_RST));
    check("scan_after_rst", 64'($countones(scan_out)), 64'h1);
    $display("Reset done");
    // Keys held through a full scan, then cleared by inhibit
    keys = 5'h1F;
    cyc(40);
    check("key_all", 64'(key_out), 64'h3FFFFFFF);
    // Pull-low enable follows a frame while keys are held
    fork
      frame(lic_pkg::DEV_ADDR, 2'h3, 4'h9, 18);
      begin
        cyc(20);
        check("oe_on", 64'(so_oe), 64'h1);
      end
    join
    check("oe_off", 64'(so_oe), 64'h0);
    check("dout", 64'(so), 64'h0);
    inhibit_n = 1'b0;
    cyc(5);
    blank();
    check("port_off", 64'(port_out), 64'h0);
    $display("Key clear done");
    wrap_up();
  end
endmodule : test_lic_inhibit_ctrl
